// File: core/pss_pkg.sv
`default_nettype none
package pss_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_STARTUP = 8'h00;
  localparam logic [7:0] ADDR_PERIPH  = 8'h04;
  localparam logic [7:0] ADDR_SERIAL  = 8'h08;
  localparam logic [7:0] ADDR_CTRL    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_PORTS   = 8'h14;

  // Reset values of the setup words
  localparam logic [15:0] RST_STARTUP = 16'h0000;
  localparam logic [15:0] RST_PERIPH  = 16'h0000;
  localparam logic [15:0] RST_SERIAL  = 16'h0000;

  // Protocol masks: bit0 console bus, 1 peripheral bus, 2 host link,
  // 3 no-protocol, 4 peer data link, 5 terminal_link
  localparam logic [5:0] MASK_CONSOLE  = 6'h01;
  localparam logic [5:0] MASK_PERI_CFG = 6'h0e;
  localparam logic [5:0] MASK_PERI_STD = 6'h06;
  localparam logic [5:0] MASK_SER_CFG  = 6'h3c;
  localparam logic [5:0] MASK_SER_STD  = 6'h04;

  // Source of a port's settings
  localparam logic [1:0] SRC_STD     = 2'h0;
  localparam logic [1:0] SRC_WORDS   = 2'h1;
  localparam logic [1:0] SRC_CONSOLE = 2'h2;

  // Operating modes and startup selector codes
  localparam logic [1:0] MODE_PROGRAM = 2'h0;
  localparam logic [1:0] MODE_MONITOR = 2'h1;
  localparam logic [1:0] MODE_RUN     = 2'h2;
  localparam logic [7:0] SEL_SWITCH   = 8'h00;
  localparam logic [7:0] SEL_RETAIN   = 8'h01;
  localparam logic [7:0] SEL_WORD     = 8'h02;

  // Kind of device found on the peripheral port
  localparam logic [1:0] ATT_NONE    = 2'h0;
  localparam logic [1:0] ATT_CONSOLE = 2'h1;

  // Standard frame: one start bit, even parity, 7 data, 2 stop, 9600 bps
  localparam logic [3:0]  STD_DATA_BITS   = 4'h7;
  localparam logic [1:0]  STD_STOP_BITS   = 2'h2;
  localparam logic [1:0]  STD_PARITY_EVEN = 2'h1;
  localparam logic [7:0]  STD_BAUD_HUND   = 8'h60;
  localparam logic [15:0] STD_CFG_WORD    =
    {STD_BAUD_HUND, STD_PARITY_EVEN, STD_STOP_BITS, STD_DATA_BITS};

  // Legal peripheral setup word values for a host on the peripheral bus
  localparam logic [15:0] PWORD_STD    = 16'h0000;
  localparam logic [15:0] PWORD_CUSTOM = 16'h0001;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decision phase
  typedef enum logic [1:0] {
    PH_WAIT = 2'b01,
    PH_DONE = 2'b10
  } pss_phase_e;
endpackage
`default_nettype wire

// File: core/pss_decode.sv
`default_nettype none
module pss_decode import pss_pkg::*; (
  // Switch pins
  input  wire logic        p5,
  input  wire logic        p7,
  // Setup words
  input  wire logic [15:0] startup_word,
  input  wire logic [15:0] periph_word,
  input  wire logic [15:0] serial_word,
  // Detection
  input  wire logic [1:0]  attach,
  input  wire logic [1:0]  console_sel,
  input  wire logic        cable_run,
  input  wire logic [1:0]  retained,
  // Decision
  output logic      [5:0]  pm,
  output logic      [1:0]  ps,
  output logic      [15:0] pc,
  output logic      [5:0]  sm,
  output logic      [1:0]  ss,
  output logic      [15:0] sc,
  output logic      [1:0]  mode,
  output logic             cons_en,
  output logic             refused,
  output logic             pbad
);
  // Unknown mode codes fall back to the safe non-running mode
  function automatic logic [1:0] clamp_mode(input logic [7:0] code);
    return (code <= {6'h00, MODE_RUN}) ? code[1:0] : MODE_PROGRAM;
  endfunction

  // Port selection
  always_comb begin
    if (!p7) begin
      pm = MASK_CONSOLE;
      ps = SRC_CONSOLE;
      pc = 16'h0000;
    end else if (!p5) begin
      pm = MASK_PERI_CFG;
      ps = SRC_WORDS;
      pc = periph_word;
    end else begin
      pm = MASK_PERI_STD;
      ps = SRC_STD;
      pc = STD_CFG_WORD;
    end
    sm = p5 ? MASK_SER_STD : MASK_SER_CFG;
    ss = p5 ? SRC_STD : SRC_WORDS;
    sc = p5 ? STD_CFG_WORD : serial_word;
    // Flag a host whose word is neither PWORD_STD nor PWORD_CUSTOM
    pbad = p7 && !p5 && (periph_word != PWORD_STD)
           && (periph_word != PWORD_CUSTOM);
    cons_en = !p7 && (attach == ATT_CONSOLE);
    refused = !p7 && (attach != ATT_NONE) && (attach != ATT_CONSOLE);
  end

  // Startup mode selection
  always_comb begin
    unique case (startup_word[15:8])
      SEL_SWITCH: begin
        if (attach == ATT_NONE)
          mode = p7 ? MODE_RUN : MODE_PROGRAM;
        else if (attach == ATT_CONSOLE)
          mode = p7 ? MODE_PROGRAM : clamp_mode({6'h00, console_sel});
        else if (p7)
          mode = cable_run ? MODE_RUN : MODE_PROGRAM;
        else
          mode = MODE_PROGRAM;
      end
      SEL_RETAIN: mode = clamp_mode({6'h00, retained});
      SEL_WORD:   mode = clamp_mode(startup_word[7:0]);
      default:    mode = MODE_PROGRAM;
    endcase
  end
endmodule
`default_nettype wire

// File: core/pss_top.sv
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`default_nettype none
// Contract
// - Peripheral-device pin off: peripheral port runs console bus only.
// - Both pins on: peripheral port fixed standard, bus and host link only.
// - Serial pin off: serial port uses its words; host, no-protocol, peer, terminal.
// - Serial pin on: serial port fixed standard, host link only.
// - Standard frame: host link, 1 start, even, 7 data, 2 stop, 9600.
// - Selector 00: mode from device pin once attachment is known.
// - Selector 01: mode retained from before last power-off.
// - Selector 02: mode from low byte, 0 program, 1 monitor, 2 run.
// - Switch start, nothing attached: program if pin off, run if on.
// - Console attached: its selector if pin off, else program, no link.
// - Other device, pin off: program mode, communication refused.
// - Other device, pin on: program or run from cable type.
module pss_top import pss_pkg::*; (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Bus write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // Bus write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // Bus write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  // Bus read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // Switch pins and detection
  input  wire logic        serial_settings_pin,
  input  wire logic        periph_device_pin,
  input  wire logic [1:0]  attach_kind,
  input  wire logic [1:0]  console_mode_sel,
  input  wire logic        cable_run_type,
  input  wire logic        detect_done,
  input  wire logic [1:0]  retained_mode,
  // Port selection
  output logic      [5:0]  periph_modes,
  output logic      [1:0]  periph_src,
  output logic      [15:0] periph_cfg,
  output logic      [5:0]  serial_modes,
  output logic      [1:0]  serial_src,
  output logic      [15:0] serial_cfg,
  // Startup selection
  output logic      [1:0]  startup_mode,
  output logic             startup_valid,
  output logic             console_comm_en,
  output logic             device_comm_refused
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [9:0]  s1;
    logic [9:0]  s2;
    pss_phase_e  phase;
    logic        commit;
    logic [15:0] w_start;
    logic [15:0] w_peri;
    logic [15:0] w_ser;
    logic        aw_got;
    logic [7:0]  aw_a;
    logic        w_got;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [5:0]  pm;
    logic [1:0]  ps;
    logic [15:0] pc;
    logic [5:0]  sm;
    logic [1:0]  ss;
    logic [15:0] sc;
    logic [1:0]  mode;
    logic        cons_en;
    logic        refused;
    logic        pbad;
  } pss_state_s;

  pss_state_s state_ff;
  pss_state_s nxt_state;

  // Synchronised pin view, all read from the second stage only
  logic        p5;
  logic        p7;
  logic [1:0]  att;
  logic [1:0]  sel;
  logic        cab;
  logic        det;
  logic [1:0]  ret;
  assign {ret, det, cab, sel, att, p7, p5} = state_ff.s2;

  // Live decision from the present pins and words
  logic [5:0]  d_pm;
  logic [1:0]  d_ps;
  logic [15:0] d_pc;
  logic [5:0]  d_sm;
  logic [1:0]  d_ss;
  logic [15:0] d_sc;
  logic [1:0]  d_mode;
  logic        d_cons;
  logic        d_ref;
  logic        d_pbad;

  pss_decode pss_decode_i (
    .p5           (p5),
    .p7           (p7),
    .startup_word (state_ff.w_start),
    .periph_word  (state_ff.w_peri),
    .serial_word  (state_ff.w_ser),
    .attach       (att),
    .console_sel  (sel),
    .cable_run    (cab),
    .retained     (ret),
    .pm           (d_pm),
    .ps           (d_ps),
    .pc           (d_pc),
    .sm           (d_sm),
    .ss           (d_ss),
    .sc           (d_sc),
    .mode         (d_mode),
    .cons_en      (d_cons),
    .refused      (d_ref),
    .pbad         (d_pbad)
  );

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge the low two byte lanes into a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Any address the slave answers with OKAY
  function automatic logic mapped(input logic [7:0] a);
    return (a == ADDR_STARTUP) || (a == ADDR_PERIPH) || (a == ADDR_SERIAL)
        || (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_PORTS);
  endfunction

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic decide;

  // Handshakes; a new write waits until the old response is taken
  assign awready = !state_ff.aw_got && !state_ff.bvalid;
  assign wready  = !state_ff.w_got && !state_ff.bvalid;
  assign arready = !state_ff.rvalid;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign ar_hs   = arvalid && arready;
  assign do_wr   = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
  // Decide once, after software commits and detection has settled
  assign decide  = (state_ff.phase == PH_WAIT) && state_ff.commit && det;

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_state = state_ff;
    // Two-stage synchroniser for every pin
    nxt_state.s1 = {retained_mode, detect_done, cable_run_type, console_mode_sel,
                    attach_kind, periph_device_pin, serial_settings_pin};
    nxt_state.s2 = state_ff.s1;

    // Write channels captured in either order
    if (aw_hs) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.aw_a   = awaddr;
    end
    if (w_hs) begin
      nxt_state.w_got = 1'b1;
      nxt_state.w_d   = wdata;
      nxt_state.w_s   = wstrb;
    end
    if (do_wr) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = mapped(state_ff.aw_a) ? RESP_OKAY : RESP_SLVERR;
      unique case (state_ff.aw_a)
        ADDR_STARTUP: nxt_state.w_start =
          merge16(state_ff.w_start, state_ff.w_d, state_ff.w_s);
        ADDR_PERIPH: nxt_state.w_peri =
          merge16(state_ff.w_peri, state_ff.w_d, state_ff.w_s);
        ADDR_SERIAL: nxt_state.w_ser =
          merge16(state_ff.w_ser, state_ff.w_d, state_ff.w_s);
        // Commit is one-shot; words written after the snapshot do not move the choice
        ADDR_CTRL: begin
          if (state_ff.w_s[0] && state_ff.w_d[0])
            nxt_state.commit = 1'b1;
        end
        default: ;
      endcase
    end else if (state_ff.bvalid && bready) begin
      nxt_state.bvalid = 1'b0;
    end

    // Read answers one edge after the address is taken
    if (ar_hs) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        ADDR_STARTUP: nxt_state.rdata = {16'h0000, state_ff.w_start};
        ADDR_PERIPH:  nxt_state.rdata = {16'h0000, state_ff.w_peri};
        ADDR_SERIAL:  nxt_state.rdata = {16'h0000, state_ff.w_ser};
        ADDR_CTRL:    nxt_state.rdata = {31'h0, state_ff.commit};
        ADDR_STATUS:  nxt_state.rdata = {26'h0, state_ff.pbad, state_ff.refused,
                                         state_ff.cons_en,
                                         state_ff.phase == PH_DONE,
                                         state_ff.mode};
        ADDR_PORTS:   nxt_state.rdata = {16'h0000, state_ff.ss, state_ff.sm,
                                         state_ff.ps, state_ff.pm};
        default:      nxt_state.rdata = 32'h0000_0000;
      endcase
    end else if (state_ff.rvalid && rready) begin
      nxt_state.rvalid = 1'b0;
    end

    // Single snapshot of the selection, held until the next reset
    unique case (state_ff.phase)
      PH_WAIT: begin
        if (decide) begin
          nxt_state.phase   = PH_DONE;
          nxt_state.pm      = d_pm;
          nxt_state.ps      = d_ps;
          nxt_state.pc      = d_pc;
          nxt_state.sm      = d_sm;
          nxt_state.ss      = d_ss;
          nxt_state.sc      = d_sc;
          nxt_state.mode    = d_mode;
          nxt_state.cons_en = d_cons;
          nxt_state.refused = d_ref;
          nxt_state.pbad    = d_pbad;
        end
      end
      PH_DONE: ;
      default: nxt_state.phase = PH_WAIT;
    endcase
  end

  // Single register for all state; safe defaults until the snapshot
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff         <= '0;
      state_ff.phase   <= PH_WAIT;
      state_ff.w_start <= RST_STARTUP;
      state_ff.w_peri  <= RST_PERIPH;
      state_ff.w_ser   <= RST_SERIAL;
      state_ff.mode    <= MODE_PROGRAM;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign bvalid              = state_ff.bvalid;
  assign bresp               = state_ff.bresp;
  assign rvalid              = state_ff.rvalid;
  assign rdata               = state_ff.rdata;
  assign rresp               = state_ff.rresp;
  assign periph_modes        = state_ff.pm;
  assign periph_src          = state_ff.ps;
  assign periph_cfg          = state_ff.pc;
  assign serial_modes        = state_ff.sm;
  assign serial_src          = state_ff.ss;
  assign serial_cfg          = state_ff.sc;
  assign startup_mode        = state_ff.mode;
  assign startup_valid       = state_ff.phase == PH_DONE;
  assign console_comm_en     = state_ff.cons_en;
  assign device_comm_refused = state_ff.refused;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Snapshot checks look one edge back, at the inputs the decision used
  sequence s_wr_both;
    state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
  endsequence
  sequence s_commit_ready;
    state_ff.commit && det && !startup_valid;
  endsequence

  chk_write_resp: assert property (s_wr_both |=> bvalid && !state_ff.aw_got)
    else $error("write not answered one edge after both channels");
  chk_snap_timing: assert property (s_commit_ready |=> startup_valid)
    else $error("selection not taken after commit and detection");
  chk_periph_console: assert property ($rose(startup_valid) && !$past(p7)
      |-> periph_modes == MASK_CONSOLE && periph_src == SRC_CONSOLE)
    else $error("peripheral port not console-only with device pin off");
  chk_periph_words: assert property ($rose(startup_valid) && $past(p7)
      && !$past(p5) |-> periph_modes == MASK_PERI_CFG
      && periph_cfg == $past(state_ff.w_peri))
    else $error("peripheral port not driven by its setup word");
  chk_periph_std: assert property ($rose(startup_valid) && $past(p7)
      && $past(p5) |-> periph_modes == MASK_PERI_STD && periph_src == SRC_STD)
    else $error("peripheral port not on standard settings");
  chk_serial_words: assert property ($rose(startup_valid) && !$past(p5)
      |-> serial_modes == MASK_SER_CFG && serial_cfg == $past(state_ff.w_ser))
    else $error("serial port not driven by its setup word");
  chk_serial_std: assert property ($rose(startup_valid) && $past(p5)
      |-> serial_modes == MASK_SER_STD && serial_src == SRC_STD)
    else $error("serial port not host link only on standard");
  chk_std_frame: assert property ($rose(startup_valid) && $past(p5)
      |-> serial_cfg == STD_CFG_WORD)
    else $error("standard frame word wrong");
  chk_pword_flag: assert property ($rose(startup_valid) && $past(p7)
      && !$past(p5) |-> state_ff.pbad == ($past(state_ff.w_peri) > PWORD_CUSTOM))
    else $error("peripheral word flag wrong");
  chk_sel_switch: assert property ($rose(startup_valid) && $past(att) == ATT_NONE
      && $past(state_ff.w_start[15:8]) == SEL_SWITCH
      |-> startup_mode == ($past(p7) ? MODE_RUN : MODE_PROGRAM))
    else $error("switch start with nothing attached wrong");
  chk_sel_retain: assert property ($rose(startup_valid) && $past(ret) <= MODE_RUN
      && $past(state_ff.w_start[15:8]) == SEL_RETAIN |-> startup_mode == $past(ret))
    else $error("retained mode not restored");
  chk_sel_word: assert property ($rose(startup_valid)
      && $past(state_ff.w_start[15:8]) == SEL_WORD
      && $past(state_ff.w_start[7:0]) <= {6'h00, MODE_RUN}
      |-> startup_mode == $past(state_ff.w_start[1:0]))
    else $error("explicit startup mode not taken");
  chk_none_run: assert property ($rose(startup_valid) && $past(p7)
      && $past(state_ff.w_start[15:8]) == SEL_SWITCH && $past(att) == ATT_NONE
      |-> startup_mode == MODE_RUN)
    else $error("unattached start with pin on not run");
  chk_console_sel: assert property ($rose(startup_valid) && !$past(p7)
      && $past(state_ff.w_start[15:8]) == SEL_SWITCH && $past(att) == ATT_CONSOLE
      && $past(sel) <= MODE_RUN |-> startup_mode == $past(sel) && console_comm_en)
    else $error("console selector not adopted");
  chk_other_off: assert property ($rose(startup_valid) && !$past(p7)
      && $past(att) > ATT_CONSOLE |-> device_comm_refused && !console_comm_en)
    else $error("foreign device not refused with pin off");
  chk_cable_mode: assert property ($rose(startup_valid) && $past(p7)
      && $past(state_ff.w_start[15:8]) == SEL_SWITCH && $past(att) > ATT_CONSOLE
      |-> startup_mode == ($past(cab) ? MODE_RUN : MODE_PROGRAM))
    else $error("cable type not steering startup mode");
  chk_hold: assert property (startup_valid |=> startup_valid
      && $stable(startup_mode) && $stable(periph_modes) && $stable(serial_cfg))
    else $error("selection moved after snapshot");
endmodule
`default_nettype wire

// File: dv/pss_far_end.sv
`default_nettype none
module pss_far_end import pss_pkg::*; (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // What sits on the port
  input  wire logic [1:0] kind,
  input  wire logic [1:0] sel,
  input  wire logic       cable,
  input  wire logic [7:0] settle,
  // Detection lines
  output logic      [1:0] attach_kind,
  output logic      [1:0] console_mode_sel,
  output logic            cable_run_type,
  output logic            detect_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] age;
  ////////////////////////////////////////
  // Detection takes time, so it may land before or after commit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      age <= 8'h00;
    end else if (age < settle) begin
      age <= age + 8'h01;
    end
  end
  assign detect_done = (age >= settle);
  assign attach_kind = kind;
  // Lines with nothing behind them show the inverse, never a kind value
  assign console_mode_sel = (kind == ATT_CONSOLE) ? sel : ~sel;
  assign cable_run_type   = kind[1] ? cable : ~cable;
endmodule
`default_nettype wire

// File: dv/port_and_startup_mode_select_test.sv
`default_nettype none
module port_and_startup_mode_select_test import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, far_cable = 1'b0;
  logic        serial_settings_pin = 1'b0, periph_device_pin = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, far_settle = 8'h02;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  far_kind = 2'h0, far_sel = 2'h0, retained_mode = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid, cable_run_type, detect_done;
  logic        startup_valid, console_comm_en, device_comm_refused;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp, attach_kind, console_mode_sel, startup_mode;
  logic [5:0]  periph_modes, serial_modes;
  logic [1:0]  periph_src, serial_src;
  logic [15:0] periph_cfg, serial_cfg;
  int          fail_count = 0, tests_run = 0;

  always #2 clock = ~clock;

  pss_top pss_top_i (.clock, .rstn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .serial_settings_pin, .periph_device_pin, .attach_kind, .console_mode_sel,
    .cable_run_type, .detect_done, .retained_mode, .periph_modes, .periph_src, .periph_cfg,
    .serial_modes, .serial_src, .serial_cfg, .startup_mode, .startup_valid, .console_comm_en,
    .device_comm_refused);

  pss_far_end pss_far_end_i (.clock, .rstn, .kind(far_kind), .sel(far_sel),
    .cable(far_cable), .settle(far_settle), .attach_kind, .console_mode_sel,
    .cable_run_type, .detect_done);

  ////////////////////////////////////////
  // Verdict and checks
  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout;
    fail_count++;
    $display("Error %0t: no answer in time", $time);
    complete_run();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////
  // Bus tasks: ready and answer sampled mid-cycle, acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic       ta, tw, tb;
    logic [1:0] rs;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'h3;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk(32'(rs), 32'(er));
        return;
      end
    end
    timeout();
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp,
                    input logic [31:0] msk);
    logic        ta, tr;
    logic [1:0]  rs;
    logic [31:0] q;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid;
      q  = rdata;
      rs = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        chk(32'(rs), 32'(er));
        chk(q & msk, exp & msk);
        return;
      end
    end
    timeout();
  endtask

  ////////////////////////////////////////
  // One power-on: reset, set words, commit, check, then try to disturb it
  task automatic run_case(input logic s5, input logic s7, input logic [1:0] ak,
    input logic [1:0] cs, input logic [1:0] rm, input logic cb, input logic [7:0] st,
    input logic [15:0] sw);
    logic [1:0]  em;
    logic [31:0] pexp, sexp, msk;
    int          n;
    @(posedge clock);
    rstn                <= 1'b0;
    serial_settings_pin <= s5;
    periph_device_pin   <= s7;
    far_kind            <= ak;
    far_sel             <= cs;
    far_cable           <= cb;
    far_settle          <= st;
    retained_mode       <= rm;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    wr(ADDR_STARTUP, sw, RESP_OKAY);
    wr(ADDR_PERIPH, PWORD_CUSTOM, RESP_OKAY);
    wr(ADDR_SERIAL, 16'h0a5c, RESP_OKAY);
    rd(ADDR_STARTUP, RESP_OKAY, {16'h0000, sw}, '1);
    wr(ADDR_CTRL, 16'h0001, RESP_OKAY);
    for (n = 0; n < 200 && startup_valid !== 1'b1; n++) @(negedge clock);
    if (n == 200) timeout();
    case (sw[15:8])
      SEL_SWITCH: em = (ak == ATT_NONE) ? (s7 ? MODE_RUN : MODE_PROGRAM) :
                       (ak == ATT_CONSOLE) ? ((s7 || cs == 2'h3) ? MODE_PROGRAM : cs) :
                       (s7 && cb) ? MODE_RUN : MODE_PROGRAM;
      SEL_RETAIN: em = rm;
      SEL_WORD:   em = (sw[7:0] > 8'h02) ? MODE_PROGRAM : sw[1:0];
      default:    em = MODE_PROGRAM;
    endcase
    pexp = !s7 ? {8'h00, SRC_CONSOLE, MASK_CONSOLE, 16'h0000} :
           !s5 ? {8'h00, SRC_WORDS, MASK_PERI_CFG, PWORD_CUSTOM} :
                 {8'h00, SRC_STD, MASK_PERI_STD, STD_CFG_WORD};
    sexp = !s5 ? {8'h00, SRC_WORDS, MASK_SER_CFG, 16'h0a5c} :
                 {8'h00, SRC_STD, MASK_SER_STD, STD_CFG_WORD};
    chk({8'h00, periph_src, periph_modes, periph_cfg}, pexp);
    chk({8'h00, serial_src, serial_modes, serial_cfg}, sexp);
    chk({30'h0, startup_mode}, {30'h0, em});
    chk({30'h0, console_comm_en, device_comm_refused},
        {30'h0, ak == ATT_CONSOLE && !s7, ak[1] && !s7});
    // Status read checks the refused flag only for the switch-governed start, and the console flag there only with a console attached
    msk = (sw[15:8] != SEL_SWITCH) ? 32'h27 : (ak == ATT_CONSOLE) ? 32'h3f : 32'h37;
    rd(ADDR_STATUS, RESP_OKAY, {26'h0, 1'b0, ak[1] & ~s7, ~s7, 1'b1, em}, msk);
    rd(ADDR_PORTS, RESP_OKAY, {16'h0000, sexp[23:16], pexp[23:16]}, '1);
    serial_settings_pin <= ~s5;
    periph_device_pin   <= ~s7;
    wr(ADDR_STARTUP, ~sw, RESP_OKAY);
    wr(ADDR_CTRL, 16'h0001, RESP_OKAY);
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk({8'h00, periph_src, periph_modes, periph_cfg}, pexp);
    chk({30'h0, startup_mode}, {30'h0, em});
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    run_case(1'b0, 1'b0, ATT_NONE, 2'h0, 2'h0, 1'b0, 8'h02, 16'h0000);
    run_case(1'b0, 1'b1, ATT_NONE, 2'h0, 2'h0, 1'b0, 8'h3c, 16'h0000);
    run_case(1'b1, 1'b1, ATT_CONSOLE, 2'h2, 2'h0, 1'b0, 8'h02, 16'h0000);
    run_case(1'b1, 1'b0, ATT_CONSOLE, 2'h1, 2'h0, 1'b0, 8'h05, 16'h0000);
    run_case(1'b0, 1'b0, ATT_CONSOLE, 2'h3, 2'h0, 1'b0, 8'h02, 16'h0000);
    run_case(1'b0, 1'b0, 2'h2, 2'h0, 2'h0, 1'b1, 8'h02, 16'h0000);
    run_case(1'b0, 1'b1, 2'h3, 2'h0, 2'h0, 1'b1, 8'h02, 16'h0000);
    run_case(1'b1, 1'b1, 2'h2, 2'h0, 2'h0, 1'b0, 8'h02, 16'h0000);
    run_case(1'b0, 1'b1, ATT_NONE, 2'h0, MODE_MONITOR, 1'b0, 8'h02, 16'h0100);
    for (int k = 0; k < 4; k++) begin
      run_case(1'b0, 1'b1, ATT_NONE, 2'h0, 2'h0, 1'b0, 8'h02, {8'h02, 8'(k)});
    end
    run_case(1'b0, 1'b1, ATT_NONE, 2'h0, 2'h0, 1'b0, 8'h02, 16'h0300);
    wr(8'h18, 16'h00ff, RESP_SLVERR);
    rd(8'h18, RESP_SLVERR, 32'h0, '1);
    rd(ADDR_CTRL, RESP_OKAY, 32'h1, '1);
    complete_run();
  end
endmodule
`default_nettype wire
